/* design/tcx_capture_compare.sv */
// Channel X capture, extra compare, output select and channel Y source pick.
`timescale 1ns/100ps
`include "tcx_cfg.svh"

module tcx_capture_compare
    import tcx_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic [3:0]       reg_addr_in,
    input  wire logic [7:0]       reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output logic      [7:0]       reg_rdata_out,
    input  wire logic [CNT_W-1:0] counter_x_in,
    input  wire logic             cma_match_in,
    input  wire logic             cmb_match_in,
    input  wire logic             ext_reset_in,
    input  wire logic             internal_vsync_pulse_in,
    input  wire logic             channel_y_clock_reset_pin_in,
    output logic                  timer_out_x_out,
    output logic                  match_c_out,
    output logic                  channel_y_source_out,
    output logic                  irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration check.

    generate
        if (CNT_W != 8) begin : g_bad_width
            $error("tcx_capture_compare serves an 8-bit counter only.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [1:0]       cmb_action_ff;
    logic [1:0]       cma_action_ff;
    logic [1:0]       flag_ff;
    logic [1:0]       flag_seen_ff;
    logic [7:0]       compare_offset_constant_ff;
    logic [7:0]       rise_edge_capture_ff;
    logic [7:0]       fall_edge_capture_ff;
    logic [7:0]       edge_capture_ff;
    logic [7:0]       input_source_select_ff;
    logic             capture_arm_ff;
    logic [2:0]       irq_status_ff;
    logic [2:0]       irq_enable_ff;
    logic [7:0]       counter_prev_ff;
    logic [7:0]       rdata_ff;
    logic             timer_out_ff;
    logic             match_c_ff;
    logic             chy_src_ff;
    logic             irq_ff;
    tcx_cap_state_t   cap_state_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic wr_ctrl;
    logic wr_offset;
    logic wr_source;
    logic wr_arm;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic rd_ctrl;
    logic rd_capture;

    assign wr_ctrl    = reg_wr_in && (reg_addr_in == `TCX_OFS_CTRL_STATUS);
    assign wr_offset  = reg_wr_in && (reg_addr_in == `TCX_OFS_OFFSET_CONST);
    assign wr_source  = reg_wr_in && (reg_addr_in == `TCX_OFS_SOURCE_SELECT);
    assign wr_arm     = reg_wr_in && (reg_addr_in == `TCX_OFS_ARM_CTRL);
    assign wr_irq_en  = reg_wr_in && (reg_addr_in == `TCX_OFS_IRQ_ENABLE);
    assign wr_irq_clr = reg_wr_in && (reg_addr_in == `TCX_OFS_IRQ_CLEAR);
    assign rd_ctrl    = reg_rd_in && (reg_addr_in == `TCX_OFS_CTRL_STATUS);
    assign rd_capture = reg_rd_in && ((reg_addr_in == `TCX_OFS_RISE_CAPTURE) ||
                                      (reg_addr_in == `TCX_OFS_FALL_CAPTURE));

    ////////////////////////////////////////////////////////////////////////////////
    // External reset input synchroniser and edge detection.

    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    logic ext_rise;
    logic ext_fall;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_meta_ff <= ext_reset_in;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
        end
    end

    assign ext_rise = ext_sync_ff && !ext_prev_ff;
    assign ext_fall = !ext_sync_ff && ext_prev_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Capture edges seen during a capture register read wait one cycle.

    logic rise_pend_ff;
    logic fall_pend_ff;
    logic cap_rise;
    logic cap_fall;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rise_pend_ff <= 1'b0;
            fall_pend_ff <= 1'b0;
        end else begin
            rise_pend_ff <= ext_rise && rd_capture;
            fall_pend_ff <= ext_fall && rd_capture;
        end
    end

    assign cap_rise = (ext_rise && !rd_capture) || rise_pend_ff;
    assign cap_fall = (ext_fall && !rd_capture) || fall_pend_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Edge capture register, visible only to the compare logic.

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            edge_capture_ff <= `TCX_RST_CAPTURE;
        end else if (ext_rise) begin
            edge_capture_ff <= counter_x_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare-match C against offset plus edge capture.

    logic [7:0] match_c_target;
    logic       nxt_match_c;

    assign match_c_target = 8'(compare_offset_constant_ff + edge_capture_ff);
    assign nxt_match_c    = (counter_x_in == match_c_target)
                            && !wr_offset && !ext_rise;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            match_c_ff <= 1'b0;
        end else begin
            match_c_ff <= nxt_match_c;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            compare_offset_constant_ff <= `TCX_RST_OFFSET_CONST;
        end else if (wr_offset) begin
            compare_offset_constant_ff <= reg_wdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Armed single rise-then-fall measurement.

    logic cap_done;

    assign cap_done = (cap_state_ff == TCX_WAIT_FALL) && cap_fall;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cap_state_ff <= TCX_IDLE;
        end else begin
            unique case (cap_state_ff)
                TCX_IDLE: begin
                    if (capture_arm_ff) begin
                        cap_state_ff <= TCX_WAIT_RISE;
                    end
                end
                TCX_WAIT_RISE: begin
                    if (!capture_arm_ff) begin
                        cap_state_ff <= TCX_IDLE;
                    end else if (cap_rise) begin
                        cap_state_ff <= TCX_WAIT_FALL;
                    end
                end
                TCX_WAIT_FALL: begin
                    if (!capture_arm_ff || cap_fall) begin
                        cap_state_ff <= TCX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rise_edge_capture_ff <= `TCX_RST_CAPTURE;
            fall_edge_capture_ff <= `TCX_RST_CAPTURE;
        end else begin
            if ((cap_state_ff == TCX_WAIT_RISE) && capture_arm_ff && cap_rise) begin
                rise_edge_capture_ff <= counter_x_in;
            end
            if (cap_done && capture_arm_ff) begin
                fall_edge_capture_ff <= counter_x_in;
            end
        end
    end

    // A software write of the arm bit wins over the self-clear.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            capture_arm_ff <= 1'b0;
        end else if (wr_arm) begin
            capture_arm_ff <= reg_wdata_in[`TCX_POS_CAPTURE_ARM];
        end else if (cap_done) begin
            capture_arm_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wrap and capture flags, cleared by read-one-then-write-zero.

    logic [7:0] counter_max;
    logic       wrap_evt;
    logic [1:0] flag_set;
    logic [1:0] flag_pos_wdata;

    assign counter_max = `TCX_RST_COUNTER_MAX;
    assign wrap_evt    = (counter_prev_ff == counter_max) &&
                         (counter_x_in == 8'h00);
    assign flag_set    = {wrap_evt, cap_done && capture_arm_ff};
    assign flag_pos_wdata = {reg_wdata_in[`TCX_POS_WRAP_FLAG],
                             reg_wdata_in[`TCX_POS_CAPTURE_FLAG]};

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            counter_prev_ff <= 8'h00;
        end else begin
            counter_prev_ff <= counter_x_in;
        end
    end

    // Bit 1 is the wrap flag and bit 0 the capture flag; a set wins over a clear.
    generate
        for (genvar i = 0; i < 2; i++) begin : g_flag
            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    flag_ff[i]      <= 1'b0;
                    flag_seen_ff[i] <= 1'b0;
                end else if (flag_set[i]) begin
                    flag_ff[i]      <= 1'b1;
                end else if (wr_ctrl && flag_seen_ff[i] && !flag_pos_wdata[i]) begin
                    flag_ff[i]      <= 1'b0;
                    flag_seen_ff[i] <= 1'b0;
                end else if (rd_ctrl && flag_ff[i]) begin
                    flag_seen_ff[i] <= 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Output select fields and timer output.

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cmb_action_ff <= `TCX_ACT_KEEP;
            cma_action_ff <= `TCX_ACT_KEEP;
        end else if (wr_ctrl) begin
            cmb_action_ff <= reg_wdata_in[`TCX_POS_CMB_ACTION +: 2];
            cma_action_ff <= reg_wdata_in[`TCX_POS_CMA_ACTION +: 2];
        end
    end

    function automatic logic apply_action(input tcx_action_t act, input logic cur);
        logic res;
        res = cur;
        unique case (act)
            `TCX_ACT_KEEP:   res = cur;
            `TCX_ACT_LOW:    res = 1'b0;
            `TCX_ACT_HIGH:   res = 1'b1;
            `TCX_ACT_TOGGLE: res = !cur;
        endcase
        return res;
    endfunction

    // When both matches land together, match B acts on the result of match A.
    logic nxt_timer_out;
    logic after_a;

    always_comb begin
        after_a       = cma_match_in ? apply_action(cma_action_ff, timer_out_ff)
                                     : timer_out_ff;
        nxt_timer_out = cmb_match_in ? apply_action(cmb_action_ff, after_a)
                                     : after_a;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            timer_out_ff <= 1'b0;
        end else begin
            timer_out_ff <= nxt_timer_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel Y source pick.

    logic chy_meta_ff;
    logic chy_sync_ff;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            chy_meta_ff <= 1'b0;
            chy_sync_ff <= 1'b0;
        end else begin
            chy_meta_ff <= channel_y_clock_reset_pin_in;
            chy_sync_ff <= chy_meta_ff;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            input_source_select_ff <= `TCX_RST_SOURCE_SELECT;
        end else if (wr_source) begin
            input_source_select_ff <= reg_wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            chy_src_ff <= 1'b0;
        end else if (input_source_select_ff[`TCX_POS_SOURCE_PICK]) begin
            chy_src_ff <= chy_sync_ff;
        end else begin
            chy_src_ff <= internal_vsync_pulse_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear.

    logic [2:0] irq_evt;

    assign irq_evt = {nxt_match_c && !match_c_ff, flag_set[0], flag_set[1]};

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_status_ff <= 3'h0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~(wr_irq_clr ? reg_wdata_in[2:0] : 3'h0))
                             | irq_evt;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_enable_ff <= 3'h0;
        end else if (wr_irq_en) begin
            irq_enable_ff <= reg_wdata_in[2:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe.

    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `TCX_OFS_CTRL_STATUS:   nxt_rdata = {2'h0, flag_ff, cmb_action_ff,
                                                     cma_action_ff};
                `TCX_OFS_OFFSET_CONST:  nxt_rdata = compare_offset_constant_ff;
                `TCX_OFS_RISE_CAPTURE:  nxt_rdata = rise_edge_capture_ff;
                `TCX_OFS_FALL_CAPTURE:  nxt_rdata = fall_edge_capture_ff;
                `TCX_OFS_SOURCE_SELECT: nxt_rdata = input_source_select_ff;
                `TCX_OFS_ARM_CTRL:      nxt_rdata = {7'h00, capture_arm_ff};
                `TCX_OFS_IRQ_STATUS:    nxt_rdata = {5'h00, irq_status_ff};
                `TCX_OFS_IRQ_ENABLE:    nxt_rdata = {5'h00, irq_enable_ff};
                default:                nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rdata_out        = rdata_ff;
    assign timer_out_x_out      = timer_out_ff;
    assign match_c_out          = match_c_ff;
    assign channel_y_source_out = chy_src_ff;
    assign irq_out              = irq_ff;

endmodule

/* design/tcx_cfg.svh */
// Constants of the channel X capture and extra compare block.
`ifndef TCX_CFG_SVH
`define TCX_CFG_SVH

// Register offsets on the plain register port.
`define TCX_OFS_CTRL_STATUS   4'h0
`define TCX_OFS_OFFSET_CONST  4'h1
`define TCX_OFS_RISE_CAPTURE  4'h2
`define TCX_OFS_FALL_CAPTURE  4'h3
`define TCX_OFS_SOURCE_SELECT 4'h4
`define TCX_OFS_ARM_CTRL      4'h5
`define TCX_OFS_IRQ_STATUS    4'h6
`define TCX_OFS_IRQ_ENABLE    4'h7
`define TCX_OFS_IRQ_CLEAR     4'h8

// Field positions of the control and status, source select and arm control registers.
`define TCX_POS_WRAP_FLAG     5
`define TCX_POS_CAPTURE_FLAG  4
`define TCX_POS_CMB_ACTION    2
`define TCX_POS_CMA_ACTION    0
`define TCX_POS_SOURCE_PICK   0
`define TCX_POS_CAPTURE_ARM   0

// Interrupt status bit positions.
`define TCX_IRQ_WRAP          0
`define TCX_IRQ_CAPTURE       1
`define TCX_IRQ_MATCH_C       2

// Output action codes.
`define TCX_ACT_KEEP          2'h0
`define TCX_ACT_LOW           2'h1
`define TCX_ACT_HIGH          2'h2
`define TCX_ACT_TOGGLE        2'h3

// Reset values.
`define TCX_RST_OFFSET_CONST  8'hFF
`define TCX_RST_CAPTURE       8'h00
`define TCX_RST_SOURCE_SELECT 8'hFE
`define TCX_RST_COUNTER_MAX   8'hFF

`endif

/* design/tcx_pkg.sv */
// Types shared by the channel X capture and extra compare block.
package tcx_pkg;
    typedef logic [1:0] tcx_action_t;
    typedef enum logic [1:0] {
        TCX_IDLE,
        TCX_WAIT_RISE,
        TCX_WAIT_FALL
    } tcx_cap_state_t;
endpackage

/* testbench/tcx_capture_compare_checker.sv */
// Port-level assertions for the channel X capture and extra compare block.
`timescale 1ns/100ps
`include "tcx_cfg.svh"

module tcx_capture_compare_checker
    import tcx_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       cma_match_in,
    input wire logic       cmb_match_in,
    input wire logic       internal_vsync_pulse_in,
    input wire logic       channel_y_clock_reset_pin_in,
    input wire logic       timer_out_x_out,
    input wire logic       match_c_out,
    input wire logic       channel_y_source_out
);
    logic [3:0] act_ff;
    logic       pick_ff;
    logic       wr_ctl;
    logic       wr_src;
    logic       wr_off;

    assign wr_ctl = reg_wr_in && reg_addr_in == `TCX_OFS_CTRL_STATUS;
    assign wr_src = reg_wr_in && reg_addr_in == `TCX_OFS_SOURCE_SELECT;
    assign wr_off = reg_wr_in && reg_addr_in == `TCX_OFS_OFFSET_CONST;

    // Shadows of the action codes and the source pick, as software last wrote them.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            act_ff  <= 4'h0;
            pick_ff <= 1'b0;
        end else begin
            if (wr_ctl) begin
                act_ff <= reg_wdata_in[3:0];
            end
            if (wr_src) begin
                pick_ff <= reg_wdata_in[`TCX_POS_SOURCE_PICK];
            end
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("Read data not zero outside a read.");
    offset_write_a: assert property (wr_off |=> !match_c_out)
        else $error("Match C not suppressed after an offset write.");
    no_match_a: assert property (!cma_match_in && !cmb_match_in
        |=> $stable(timer_out_x_out))
        else $error("Timer output moved without a match.");
    a_low_a: assert property (cma_match_in && !cmb_match_in && !wr_ctl
        && act_ff[1:0] == `TCX_ACT_LOW |=> !timer_out_x_out)
        else $error("Match A low action failed.");
    a_high_a: assert property (cma_match_in && !cmb_match_in && !wr_ctl
        && act_ff[1:0] == `TCX_ACT_HIGH |=> timer_out_x_out)
        else $error("Match A high action failed.");
    b_toggle_a: assert property (cmb_match_in && !cma_match_in && !wr_ctl
        && act_ff[3:2] == `TCX_ACT_TOGGLE |=> timer_out_x_out != $past(timer_out_x_out))
        else $error("Match B toggle failed.");
    vsync_path_a: assert property (!pick_ff && !wr_src
        |=> channel_y_source_out == $past(internal_vsync_pulse_in))
        else $error("Vsync source not passed.");
    pin_path_a: assert property (pick_ff && !wr_src
        |=> channel_y_source_out == $past(channel_y_clock_reset_pin_in, 3))
        else $error("Pin source not passed.");
endmodule

bind tcx_capture_compare tcx_capture_compare_checker #(.CNT_W(CNT_W)) i_checker (.mclk_in,
    .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cma_match_in,
    .cmb_match_in, .internal_vsync_pulse_in, .channel_y_clock_reset_pin_in, .timer_out_x_out,
    .match_c_out, .channel_y_source_out);

/* testbench/tcx_far_side.sv */
// Far-side model: the channel X counter and the external reset pin.
`timescale 1ns/100ps

module tcx_far_side (
    input  wire logic       mclk_in,
    output logic      [7:0] counter_out,
    output logic            ext_reset_out
);
    logic run = 1'b0;

    initial begin
        counter_out = 8'h00;
        ext_reset_out = 1'b0;
    end

    always @(posedge mclk_in) begin
        if (run) begin
            counter_out <= counter_out + 8'h01;
        end
    end

    // Stopping first and loading one edge later keeps the two writers apart.
    task automatic hold(input logic [7:0] v);
        @(posedge mclk_in);
        run <= 1'b0;
        @(posedge mclk_in);
        counter_out <= v;
    endtask

    task automatic go();
        @(posedge mclk_in);
        run <= 1'b1;
    endtask

    task automatic level(input logic v);
        @(posedge mclk_in);
        ext_reset_out <= v;
    endtask
endmodule

/* testbench/test_tcx_capture_compare.sv */
// Self-checking bench for the channel X capture and extra compare block.
`timescale 1ns/100ps
`include "tcx_cfg.svh"

module test_tcx_capture_compare import tcx_pkg::*;;
    logic       mclk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic       cma_match_in = 1'b0;
    logic       cmb_match_in = 1'b0;
    logic       internal_vsync_pulse_in = 1'b0;
    logic       channel_y_clock_reset_pin_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [7:0] counter_x_in;
    logic       ext_reset_in;
    logic       timer_out_x_out;
    logic       match_c_out;
    logic       channel_y_source_out;
    logic       irq_out;
    int         seed = 38;
    int         miscompares = 0;
    int         total_checks = 0;
    logic [7:0] d;
    logic [7:0] o;
    logic [7:0] e;
    logic [3:0] acts;
    logic       tv;

    always #2 mclk_in = ~mclk_in;

    tcx_capture_compare #(.CNT_W(8)) i_tcx_capture_compare (.mclk_in, .rst_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .counter_x_in, .cma_match_in,
        .cmb_match_in, .ext_reset_in, .internal_vsync_pulse_in, .channel_y_clock_reset_pin_in,
        .timer_out_x_out, .match_c_out, .channel_y_source_out, .irq_out);
    tcx_far_side i_tcx_far_side (.mclk_in, .counter_out(counter_x_in),
        .ext_reset_out(ext_reset_in));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic act(input logic cur, input logic [1:0] code);
        case (code)
            `TCX_ACT_LOW:    act = 1'b0;
            `TCX_ACT_HIGH:   act = 1'b1;
            `TCX_ACT_TOGGLE: act = ~cur;
            default:         act = cur;
        endcase
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
            miscompares++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp, what);
    endtask

    // The first read after each pin change is strobed in the cycle in which the
    // synchronised edge lands, so that capture is deferred by one cycle.
    task automatic pulse(input logic [7:0] r, input logic [7:0] f);
        logic [7:0] junk;
        i_tcx_far_side.hold(r);
        i_tcx_far_side.level(1'b1);
        @(posedge mclk_in);
        rd(`TCX_OFS_RISE_CAPTURE, junk);
        rd(`TCX_OFS_FALL_CAPTURE, junk);
        i_tcx_far_side.hold(f);
        i_tcx_far_side.level(1'b0);
        @(posedge mclk_in);
        rd(`TCX_OFS_FALL_CAPTURE, junk);
        rd(`TCX_OFS_RISE_CAPTURE, junk);
        tick(4);
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        miscompares++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        rchk(`TCX_OFS_OFFSET_CONST, 8'hFF, "offset reset");
        rchk(`TCX_OFS_RISE_CAPTURE, 8'h00, "rise reset");
        rchk(`TCX_OFS_FALL_CAPTURE, 8'h00, "fall reset");
        rchk(`TCX_OFS_SOURCE_SELECT, 8'hFE, "source reset");
        rchk(`TCX_OFS_CTRL_STATUS, 8'h00, "ctrl reset");
        wr(`TCX_OFS_RISE_CAPTURE, 8'h5A);
        rchk(`TCX_OFS_RISE_CAPTURE, 8'h00, "rise write");
        rchk(4'hF, 8'h00, "unmapped");
        o = 8'($random(seed));
        wr(`TCX_OFS_OFFSET_CONST, o);
        rchk(`TCX_OFS_OFFSET_CONST, o, "offset rw");
        $display("register test done");
        tv = 1'b0;
        for (int i = 0; i < 48; i++) begin
            d = 8'($random(seed));
            acts = d[3:0];
            wr(`TCX_OFS_CTRL_STATUS, {4'h0, acts});
            @(posedge mclk_in);
            cma_match_in <= d[4];
            cmb_match_in <= d[5];
            @(posedge mclk_in);
            cma_match_in <= 1'b0;
            cmb_match_in <= 1'b0;
            tv = d[4] ? act(tv, acts[1:0]) : tv;
            tv = d[5] ? act(tv, acts[3:2]) : tv;
            #1 chk({7'h00, timer_out_x_out}, {7'h00, tv}, "timer out");
        end
        $display("output select test done");
        wr(`TCX_OFS_IRQ_CLEAR, 8'h07);
        wr(`TCX_OFS_IRQ_ENABLE, 8'h01);
        i_tcx_far_side.hold(8'hFD);
        i_tcx_far_side.go();
        tick(5);
        chk({7'h00, irq_out}, 8'h01, "wrap irq");
        i_tcx_far_side.hold(8'h10);
        wr(`TCX_OFS_CTRL_STATUS, {4'h0, acts});
        rchk(`TCX_OFS_CTRL_STATUS, {4'h2, acts}, "clear unread");
        wr(`TCX_OFS_CTRL_STATUS, {4'h3, acts});
        rchk(`TCX_OFS_CTRL_STATUS, {4'h2, acts}, "write one");
        wr(`TCX_OFS_CTRL_STATUS, {4'h0, acts});
        rchk(`TCX_OFS_CTRL_STATUS, {4'h0, acts}, "wrap cleared");
        wr(`TCX_OFS_IRQ_ENABLE, 8'h00);
        tick(1);
        chk({7'h00, irq_out}, 8'h00, "irq masked");
        wr(`TCX_OFS_IRQ_ENABLE, 8'h01);
        tick(1);
        chk({7'h00, irq_out}, 8'h01, "irq unmasked");
        wr(`TCX_OFS_IRQ_CLEAR, 8'h01);
        rd(`TCX_OFS_IRQ_STATUS, d);
        chk(d & 8'h01, 8'h00, "irq cleared");
        chk({7'h00, irq_out}, 8'h00, "irq low");
        $display("wrap flag test done");
        pulse(8'h21, 8'h43);
        rchk(`TCX_OFS_RISE_CAPTURE, 8'h00, "unarmed rise");
        rchk(`TCX_OFS_CTRL_STATUS, {4'h0, acts}, "unarmed flag");
        wr(`TCX_OFS_IRQ_ENABLE, 8'h02);
        wr(`TCX_OFS_ARM_CTRL, 8'h01);
        d = 8'($random(seed));
        e = 8'($random(seed));
        pulse(d, e);
        rchk(`TCX_OFS_RISE_CAPTURE, d, "rise value");
        rchk(`TCX_OFS_FALL_CAPTURE, e, "fall value");
        rchk(`TCX_OFS_ARM_CTRL, 8'h00, "arm cleared");
        chk({7'h00, irq_out}, 8'h01, "capture irq");
        rchk(`TCX_OFS_CTRL_STATUS, {4'h1, acts}, "capture flag");
        wr(`TCX_OFS_CTRL_STATUS, {4'h0, acts});
        rchk(`TCX_OFS_CTRL_STATUS, {4'h0, acts}, "capture cleared");
        pulse(8'h5C, 8'h9E);
        rchk(`TCX_OFS_RISE_CAPTURE, d, "single rise");
        rchk(`TCX_OFS_FALL_CAPTURE, e, "single fall");
        $display("capture test done");
        o = 8'($random(seed));
        wr(`TCX_OFS_OFFSET_CONST, o);
        i_tcx_far_side.hold(8'(o + 8'h5C));
        tick(3);
        chk({7'h00, match_c_out}, 8'h01, "match c hit");
        wr(`TCX_OFS_OFFSET_CONST, o);
        i_tcx_far_side.hold(8'(o + 8'h5D));
        tick(3);
        chk({7'h00, match_c_out}, 8'h00, "match c miss");
        $display("compare c test done");
        for (int k = 0; k < 2; k++) begin
            wr(`TCX_OFS_SOURCE_SELECT, {7'h7F, k[0]});
            repeat (60) begin
                @(posedge mclk_in);
                internal_vsync_pulse_in <= 1'($random(seed));
                channel_y_clock_reset_pin_in <= 1'($random(seed));
            end
        end
        rchk(`TCX_OFS_SOURCE_SELECT, 8'hFF, "source pick");
        $display("source test done");
        conclude();
    end
endmodule
